// ==== logic/probe_target_pin_mux_status_leds.sv ====
// Target connector pin multiplexer and two-indicator status controller.
// Assumes synchronous inputs from the probe controller and external pull-ups.
`timescale 1ns/1ps
`include "pin_mux_map.svh"
module probe_target_pin_mux_status_leds
  import pin_mux_pkg::*;
#(
  parameter int SLOW_HALF = (`SLOW_BLINK_MS * `CLK_KHZ),
  parameter int FAST_HALF = (`FAST_BLINK_MS * `CLK_KHZ),
  parameter int FLASH_HALF = (`FLASH_MS * `CLK_KHZ)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire pin_mux_pkg::proto_t proto_sel,
  input wire logic cmd_valid,
  input wire logic [19:0] cmd_baud,
  input wire logic jtag_tdi,
  input wire logic jtag_tms,
  input wire logic jtag_tck,
  input wire logic jtag_test,
  input wire logic jtag_rst,
  input wire logic two_wire_clock,
  input wire logic two_wire_data_out,
  input wire logic two_wire_data_drive,
  input wire logic uart_to_target,
  input wire logic cts_to_target,
  input wire logic host_connected,
  input wire logic probe_ready,
  input wire logic waiting_transfer,
  input wire logic transfer_active,
  input wire logic error_flag,
  input wire logic fw_update,
  input wire logic logic_update,
  input wire logic tdo_pin_i,
  input wire logic rst_pin_i,
  input wire logic shared_target_tx_pin_i,
  input wire logic rts_pin_i,
  output logic tdi_pin_o,
  output logic tdi_pin_oe_n,
  output logic tms_pin_o,
  output logic tms_pin_oe_n,
  output logic tck_pin_o,
  output logic tck_pin_oe_n,
  output logic test_pin_o,
  output logic test_pin_oe_n,
  output logic rst_pin_o,
  output logic rst_pin_oe_n,
  output logic shared_target_rx_pin_o,
  output logic shared_target_rx_pin_oe_n,
  output logic cts_pin_o,
  output logic cts_pin_oe_n,
  output logic tdo_sample,
  output logic two_wire_data_in,
  output logic uart_from_target,
  output logic rts_from_target,
  output logic power_led,
  output logic mode_led
);
  // Equal rates would make the two update patterns look alike
  if (FAST_HALF >= SLOW_HALF) begin : g_rate_check
    $error("fast blink must be faster than slow blink");
  end
  if (FLASH_HALF < 2) begin : g_flash_check
    $error("flash half period too small");
  end

  typedef struct packed {
    mux_state_t mux;
    proto_t proto;
    logic bc_on;
    logic tdi_o, tdi_oe_n, tms_o, tms_oe_n, tck_o, tck_oe_n;
    logic test_o, test_oe_n, rst_o, rst_oe_n;
    logic rx_o, rx_oe_n, cts_o, cts_oe_n;
    logic tdo_s, twd_in, uart_in, rts_in;
    logic pwr, mode;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;
  bc_mode_t bc_mode;
  logic slow_wave;
  logic fast_wave;
  logic flash_wave;

  bc_cmd_decode u_dec (
    .clk(clk),
    .arst_n(arst_n),
    .cmd_valid(cmd_valid),
    .cmd_baud(cmd_baud),
    .bc_mode(bc_mode)
  );

  blink_gen #(.HALF_CYCLES(SLOW_HALF)) u_slow (
    .clk(clk), .arst_n(arst_n), .wave(slow_wave)
  );
  blink_gen #(.HALF_CYCLES(FAST_HALF)) u_fast (
    .clk(clk), .arst_n(arst_n), .wave(fast_wave)
  );
  blink_gen #(.HALF_CYCLES(FLASH_HALF)) u_flash (
    .clk(clk), .arst_n(arst_n), .wave(flash_wave)
  );

  always_comb begin
    next_st = st;
    next_st.tdi_oe_n = 1'b1;
    next_st.tms_oe_n = 1'b1;
    next_st.tck_oe_n = 1'b1;
    next_st.test_oe_n = 1'b1;
    next_st.rst_oe_n = 1'b1;
    next_st.tdi_o = 1'b1;
    next_st.tms_o = 1'b1;
    next_st.tck_o = 1'b1;
    next_st.test_o = 1'b0;
    next_st.rst_o = 1'b1;
    unique case (st.mux)
      mux_safe: begin
        if (proto_sel != proto_idle) begin
          next_st.mux = mux_gap;
          next_st.proto = proto_sel;
        end
      end
      mux_gap: begin
        next_st.mux = (proto_sel == st.proto) ? mux_run : mux_safe;
      end
      mux_run: begin
        if (proto_sel != st.proto) begin
          next_st.mux = mux_safe;
          next_st.proto = proto_idle;
        end
      end
    endcase
    if (st.mux == mux_run && proto_sel == st.proto) begin
      if (st.proto == proto_jtag) begin
        next_st.tdi_o = jtag_tdi;
        next_st.tms_o = jtag_tms;
        next_st.tck_o = jtag_tck;
        next_st.test_o = jtag_test;
        next_st.rst_o = jtag_rst;
        next_st.tdi_oe_n = 1'b0;
        next_st.tms_oe_n = 1'b0;
        next_st.tck_oe_n = 1'b0;
        next_st.test_oe_n = 1'b0;
        next_st.rst_oe_n = 1'b0;
      end else if (st.proto == proto_two_wire) begin
        next_st.tck_o = two_wire_clock;
        next_st.tck_oe_n = 1'b0;
        next_st.rst_o = two_wire_data_out;
        next_st.rst_oe_n = ~two_wire_data_drive;
      end
    end
    next_st.tdo_s = (st.proto == proto_jtag) ? tdo_pin_i : 1'b0;
    next_st.twd_in = (st.proto == proto_two_wire) ? rst_pin_i : 1'b0;
    // backchannel gated by command, gap first
    next_st.bc_on = (bc_mode != bc_off);
    next_st.rx_oe_n = 1'b1;
    next_st.cts_oe_n = 1'b1;
    next_st.rx_o = 1'b1;
    next_st.cts_o = 1'b1;
    if (st.bc_on && bc_mode != bc_off) begin
      next_st.rx_o = uart_to_target;
      next_st.rx_oe_n = 1'b0;
      next_st.cts_o = (bc_mode == bc_handshake) ? cts_to_target : 1'b0;
      next_st.cts_oe_n = 1'b0;
    end
    next_st.uart_in = st.bc_on ? shared_target_tx_pin_i : 1'b1;
    next_st.rts_in = (st.bc_on && bc_mode == bc_handshake) ? rts_pin_i : 1'b0;
    if (logic_update) begin
      next_st.pwr = fast_wave;
      next_st.mode = fast_wave;
    end else if (fw_update) begin
      next_st.pwr = slow_wave;
      next_st.mode = slow_wave;
    end else if (!host_connected || !probe_ready) begin
      next_st.pwr = 1'b0;
      next_st.mode = 1'b0;
    end else if (error_flag) begin
      next_st.pwr = 1'b0;
      next_st.mode = 1'b1;
    end else if (transfer_active) begin
      next_st.pwr = 1'b1;
      next_st.mode = flash_wave;
    end else if (waiting_transfer) begin
      next_st.pwr = 1'b1;
      next_st.mode = 1'b1;
    end else begin
      next_st.pwr = 1'b1;
      next_st.mode = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{mux: mux_safe, proto: proto_idle, bc_on: 1'b0,
              tdi_o: 1'b1, tdi_oe_n: 1'b1, tms_o: 1'b1, tms_oe_n: 1'b1,
              tck_o: 1'b1, tck_oe_n: 1'b1, test_o: 1'b0, test_oe_n: 1'b1,
              rst_o: 1'b1, rst_oe_n: 1'b1, rx_o: 1'b1, rx_oe_n: 1'b1,
              cts_o: 1'b1, cts_oe_n: 1'b1, tdo_s: 1'b0, twd_in: 1'b0,
              uart_in: 1'b1, rts_in: 1'b0, pwr: 1'b0, mode: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign tdi_pin_o = st.tdi_o;
  assign tdi_pin_oe_n = st.tdi_oe_n;
  assign tms_pin_o = st.tms_o;
  assign tms_pin_oe_n = st.tms_oe_n;
  assign tck_pin_o = st.tck_o;
  assign tck_pin_oe_n = st.tck_oe_n;
  assign test_pin_o = st.test_o;
  assign test_pin_oe_n = st.test_oe_n;
  assign rst_pin_o = st.rst_o;
  assign rst_pin_oe_n = st.rst_oe_n;
  assign shared_target_rx_pin_o = st.rx_o;
  assign shared_target_rx_pin_oe_n = st.rx_oe_n;
  assign cts_pin_o = st.cts_o;
  assign cts_pin_oe_n = st.cts_oe_n;
  assign tdo_sample = st.tdo_s;
  assign two_wire_data_in = st.twd_in;
  assign uart_from_target = st.uart_in;
  assign rts_from_target = st.rts_in;
  assign power_led = st.pwr;
  assign mode_led = st.mode;

  sequence s_enter_jtag;
    (st.mux == mux_safe && proto_sel == proto_jtag) ##1 (proto_sel == proto_jtag) [*2];
  endsequence

  a_safe_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (st.mux == mux_safe) |=> (tdi_pin_oe_n && tms_pin_oe_n && test_pin_oe_n))
    else $error("pins driven while in safe state");
  a_jtag_drive: assert property (@(posedge clk) disable iff (!arst_n)
    s_enter_jtag |=> (!tdi_pin_oe_n && !tck_pin_oe_n && !rst_pin_oe_n))
    else $error("JTAG pins not driven after entry");
  a_two_wire_rel: assert property (@(posedge clk) disable iff (!arst_n)
    (st.proto == proto_two_wire) |=> (tdi_pin_oe_n && tms_pin_oe_n && test_pin_oe_n))
    else $error("two-wire mode drives released pins");
  a_bc_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (bc_mode == bc_off) |=> (shared_target_rx_pin_oe_n && cts_pin_oe_n))
    else $error("backchannel pins driven while off");
  a_bc_drive: assert property (@(posedge clk) disable iff (!arst_n)
    (st.bc_on && bc_mode != bc_off) |=> (!shared_target_rx_pin_oe_n && !cts_pin_oe_n))
    else $error("backchannel outputs not driven");
  a_err_pattern: assert property (@(posedge clk) disable iff (!arst_n)
    (!logic_update && !fw_update && host_connected && probe_ready && error_flag)
    |=> (!power_led && mode_led))
    else $error("error pattern wrong");
  a_led_off: assert property (@(posedge clk) disable iff (!arst_n)
    (!logic_update && !fw_update && !host_connected) |=> (!power_led && !mode_led))
    else $error("indicators lit while disconnected");
  a_update_both: assert property (@(posedge clk) disable iff (!arst_n)
    (fw_update || logic_update) |=> (power_led == mode_led))
    else $error("update indicators not in step");
  a_no_overlap: assert property (@(posedge clk) disable iff (!arst_n)
    (st.mux == mux_run && proto_sel != st.proto) |=> tdi_pin_oe_n [*2])
    else $error("drive kept across protocol change");
endmodule : probe_target_pin_mux_status_leds

// ==== logic/pin_mux_map.svh ====
// Constants for the target pin multiplexer and indicator logic.
// Assumes inclusion by bare name from design files only.
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH
`define BAUD_BC_OFF 20'h02594
`define BAUD_BC_PLAIN 20'h02595
`define BAUD_BC_HS 20'h02596
`define FLASH_MS 10
`define SLOW_BLINK_MS 500
`define FAST_BLINK_MS 100
`define CLK_KHZ 100000
`endif

// ==== logic/pin_mux_pkg.sv ====
// Types shared by the pin multiplexer files.
// Assumes the map header for numeric constants.
package pin_mux_pkg;
  typedef enum logic [1:0] {proto_idle, proto_jtag, proto_two_wire} proto_t;
  typedef enum logic [1:0] {bc_off, bc_plain, bc_handshake} bc_mode_t;
  typedef enum logic [1:0] {mux_safe, mux_gap, mux_run} mux_state_t;
endpackage : pin_mux_pkg

// ==== logic/blink_gen.sv ====
// Free running half-period toggle used for the indicator patterns.
// Assumes one clock domain; half period given in cycles.
`timescale 1ns/1ps
module blink_gen #(
  parameter int HALF_CYCLES = 1000
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic wave
);
  // One-cycle halves would hide a stuck toggle from the period check
  if (HALF_CYCLES < 2) begin : g_half_check
    $error("blink half period too small");
  end
  typedef struct packed {
    logic [31:0] count;
    logic wave;
  } blink_state_t;
  blink_state_t st;
  blink_state_t next_st;
  always_comb begin
    next_st = st;
    if (st.count == 32'(HALF_CYCLES - 1)) begin
      next_st.count = 32'h00000000;
      next_st.wave = ~st.wave;
    end else begin
      next_st.count = st.count + 32'h00000001;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign wave = st.wave;
  a_wave_period: assert property (@(posedge clk) disable iff (!arst_n)
    (st.count == 32'(HALF_CYCLES - 1)) |=> (wave != $past(wave)))
    else $error("blink wave did not toggle at period end");
endmodule : blink_gen

// ==== logic/bc_cmd_decode.sv ====
// Decodes the host baud-rate activation code into a backchannel mode.
// Assumes cmd_valid is a one-cycle pulse with cmd_baud stable.
`timescale 1ns/1ps
module bc_cmd_decode
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [19:0] cmd_baud,
  output pin_mux_pkg::bc_mode_t bc_mode
);
`include "pin_mux_map.svh"
  typedef struct packed {
    bc_mode_t mode;
  } dec_state_t;
  dec_state_t st;
  dec_state_t next_st;
  always_comb begin
    next_st = st;
    if (cmd_valid) begin
      if (cmd_baud == `BAUD_BC_OFF) next_st.mode = bc_off;
      else if (cmd_baud == `BAUD_BC_PLAIN) next_st.mode = bc_plain;
      else if (cmd_baud == `BAUD_BC_HS) next_st.mode = bc_handshake;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{mode: bc_off};
    end else begin
      st <= next_st;
    end
  end
  assign bc_mode = st.mode;
  a_off_code: assert property (@(posedge clk) disable iff (!arst_n)
    (cmd_valid && cmd_baud == `BAUD_BC_OFF) |=> (bc_mode == bc_off))
    else $error("off code did not disable backchannel");
  a_hold_mode: assert property (@(posedge clk) disable iff (!arst_n)
    !cmd_valid |=> $stable(bc_mode))
    else $error("backchannel mode changed without command");
endmodule : bc_cmd_decode

// ==== tb/target_model.sv ====
// Behavioural target: debug, two-wire data and backchannel pins at the far end.
// Assumes the bench resolves nothing else; pins change on the falling edge.
`timescale 1ns/1ps
module target_model (
  input wire logic clk,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n,
  input wire logic reply,
  output wire logic tdo,
  output wire logic tx,
  output wire logic rts,
  output wire logic rst_wire
);
  logic [2:0] pattern = 3'h5;
  logic reply_data = 1'b0;
  // Outputs keep moving so a stale sample never matches by luck
  always @(negedge clk) begin
    pattern <= pattern + 3'h3;
    reply_data <= ~reply_data;
  end
  assign tdo = pattern[0];
  assign tx = pattern[1];
  assign rts = pattern[2];
  // follow the probe when it drives; when released, reply if asked, else pull-up
  assign rst_wire = !rst_pin_oe_n ? rst_pin_o : (reply ? reply_data : 1'b1);
endmodule : target_model

// ==== tb/test_probe_target_pin_mux_status_leds.sv ====
// Self-checking bench for the pin multiplexer and status indicators.
// Assumes the design files and the target model are compiled before it.
`timescale 1ns/1ps
module test_probe_target_pin_mux_status_leds;
  import pin_mux_pkg::*;
  // Short blink counts keep the run brief
  localparam int SLOW = 40;
  localparam int FAST = 10;
  localparam int FLASH = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  proto_t proto_sel = proto_idle;
  logic cmd_valid = 1'b0;
  logic [19:0] cmd_baud = 20'h00000;
  logic [4:0] jtag_in = 5'h00;
  logic [4:0] misc = 5'h00;
  logic [6:0] led_in = 7'h00;
  logic reply = 1'b0;
  logic seen;
  integer seed = 32'hab06954b;
  int fails = 0;
  int samples_checked = 0;
  int exp_q[$];
  wire [6:0] oe_n;
  wire [6:0] po;
  wire [3:0] smp;
  wire [1:0] led;
  wire tdo, tx, rts, rst_wire;
  logic [8:0] tbl [6] = '{{7'h02, 2'b00}, {7'h03, 2'b10}, {7'h07, 2'b11},
    {7'h17, 2'b01}, {7'h1C, 2'b00}, {7'h14, 2'b00}};
  always #5 clk = ~clk;
  probe_target_pin_mux_status_leds #(.SLOW_HALF(SLOW), .FAST_HALF(FAST),
    .FLASH_HALF(FLASH)) dut (
    .clk(clk), .arst_n(arst_n), .proto_sel(proto_sel), .cmd_valid(cmd_valid),
    .cmd_baud(cmd_baud), .jtag_tdi(jtag_in[0]), .jtag_tms(jtag_in[1]),
    .jtag_tck(jtag_in[2]), .jtag_test(jtag_in[3]), .jtag_rst(jtag_in[4]),
    .two_wire_clock(misc[0]), .two_wire_data_out(misc[1]),
    .two_wire_data_drive(misc[2]), .uart_to_target(misc[3]), .cts_to_target(misc[4]),
    .host_connected(led_in[0]), .probe_ready(led_in[1]), .waiting_transfer(led_in[2]),
    .transfer_active(led_in[3]), .error_flag(led_in[4]), .fw_update(led_in[5]),
    .logic_update(led_in[6]), .tdo_pin_i(tdo), .rst_pin_i(rst_wire),
    .shared_target_tx_pin_i(tx), .rts_pin_i(rts),
    .tdi_pin_o(po[0]), .tdi_pin_oe_n(oe_n[0]), .tms_pin_o(po[1]), .tms_pin_oe_n(oe_n[1]),
    .tck_pin_o(po[2]), .tck_pin_oe_n(oe_n[2]), .test_pin_o(po[3]), .test_pin_oe_n(oe_n[3]),
    .rst_pin_o(po[4]), .rst_pin_oe_n(oe_n[4]), .shared_target_rx_pin_o(po[5]),
    .shared_target_rx_pin_oe_n(oe_n[5]), .cts_pin_o(po[6]), .cts_pin_oe_n(oe_n[6]),
    .tdo_sample(smp[0]), .two_wire_data_in(smp[1]), .uart_from_target(smp[2]),
    .rts_from_target(smp[3]), .power_led(led[1]), .mode_led(led[0])
  );
  target_model partner (
    .clk(clk), .rst_pin_o(po[4]), .rst_pin_oe_n(oe_n[4]), .reply(reply),
    .tdo(tdo), .tx(tx), .rts(rts), .rst_wire(rst_wire)
  );
  task automatic complete_run;
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Steady indicator patterns as {power, mode}; no update or transfer flags
  function automatic int led_model(input int f);
    if (!f[0] || !f[1]) return 0;
    if (f[4]) return 1;
    if (f[2]) return 3;
    return 2;
  endfunction : led_model
  // Inputs always move one nanosecond after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic send(input logic [19:0] code);
    cmd_baud = code;
    cmd_valid = 1'b1;
    step(1);
    cmd_valid = 1'b0;
  endtask : send
  // Half period: cycles between two changes of one indicator, bounded
  task automatic meas(input int sel, input int exp, input string what);
    logic last;
    int n;
    int h;
    n = 0;
    h = 0;
    // Let a pattern switch settle so only true toggles are timed
    step(2);
    last = led[sel];
    while (n < 300 && led[sel] === last) begin
      step(1);
      n++;
    end
    last = led[sel];
    while (n < 300 && led[sel] === last) begin
      step(1);
      n++;
      h++;
    end
    if (n >= 300) begin
      fails++;
      complete_run();
    end else begin
      chk(what, exp, h);
    end
  endtask : meas
  initial begin
    step(8);
    chk("reset state", {7'h7F, 7'h77, 4'h4, 2'h0}, {oe_n, po, smp, led});
    step(8);
    arst_n = 1'b1;
    step(3);
    chk("idle oe_n", 7'h7F, oe_n);
    proto_sel = proto_jtag;
    step(4);
    for (int i = 0; i < 4; i++) begin
      jtag_in = 5'($random(seed));
      exp_q.push_back(int'(jtag_in));
      step(2);
      chk("jtag oe_n", 7'h60, oe_n);
      chk("jtag out", exp_q.pop_front(), po[4:0]);
      chk("jtag tdo", tdo, smp[0]);
    end
    proto_sel = proto_two_wire;
    seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      step(1);
      if (oe_n[4:0] === 5'h1F) seen = 1'b1;
    end
    chk("switch gap", 1'b1, seen);
    for (int i = 0; i < 6; i++) begin
      misc = 5'($random(seed));
      reply = ~misc[2];
      step(3);
      chk("2w oe_n", {~misc[2], 4'hB}, oe_n[4:0]);
      chk("2w clock", misc[0], po[2]);
      if (misc[2]) chk("2w data out", misc[1], po[4]);
      chk("2w data in", rst_wire, smp[1]);
    end
    send(20'h02597);
    step(5);
    chk("bc ignored", 2'b11, oe_n[6:5]);
    send(20'h02595);
    step(5);
    chk("plain oe_n", 2'b00, oe_n[6:5]);
    chk("plain rx cts", {misc[3], 1'b0}, {po[5], po[6]});
    chk("plain inputs", {1'b0, tx}, smp[3:2]);
    send(20'h02596);
    step(5);
    chk("hs cts", misc[4], po[6]);
    chk("hs inputs", {rts, tx}, smp[3:2]);
    send(20'h02594);
    step(4);
    chk("bc off", 2'b11, oe_n[6:5]);
    for (int i = 0; i < 6; i++) begin
      led_in = tbl[i][8:2];
      step(2);
      chk("indicators", tbl[i][1:0], led);
    end
    for (int i = 0; i < 8; i++) begin
      led_in = 7'($random(seed)) & 7'h17;
      step(2);
      chk("indicator model", led_model(int'(led_in)), led);
    end
    led_in = 7'h0B;
    step(2);
    chk("flash power", 1'b1, led[1]);
    meas(0, FLASH, "flash half");
    led_in = 7'h20;
    meas(1, SLOW, "slow power half");
    meas(0, SLOW, "slow mode half");
    led_in = 7'h73;
    meas(1, FAST, "fast power half");
    meas(0, FAST, "fast mode half");
    arst_n = 1'b0;
    step(2);
    chk("mid reset", {7'h7F, 7'h77, 4'h4, 2'h0}, {oe_n, po, smp, led});
    arst_n = 1'b1;
    step(2);
    chk("reentry gap", 5'h1F, oe_n[4:0]);
    step(1);
    chk("reentry clock", 1'b0, oe_n[2]);
    complete_run();
  end
endmodule : test_probe_target_pin_mux_status_leds
